// file: design/tir_regs.sv
// interrupt enable and sticky status registers with a serial host port
// assumes event inputs come from other domains and the host port clock is its own domain
`timescale 1ns/1ps
module tir_regs #(
    parameter bit EXTENDED = 1'b1               // 1: pin and second transmit input present
) (
    // core clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // serial host port, its clock is a domain of its own
    input  wire logic       spi_sck_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_mosi_i,
    output logic            spi_miso_o,
    output logic            spi_miso_oe_o,
    // system event sources, asynchronous levels
    input  wire logic       can_wake_i,
    input  wire logic       overtemp_i,
    input  wire logic       serial_fail_i,
    input  wire logic       core_uv_i,
    input  wire logic       logic_uv_long_i,
    input  wire logic       wake_pin_i,
    // CAN and pin event sources, asynchronous levels
    input  wire logic       bus_silence_i,
    input  wire logic       bus_dominant_i,
    input  wire logic       tx2_timeout_i,
    input  wire logic       tx_timeout_i,
    input  wire logic       frame_error_i,
    input  wire logic [2:0] pin_event_i,
    // system enables held elsewhere, same clock
    input  wire logic [6:0] sys_irq_en_i,
    // requests out
    output logic            irq_o,
    output logic            wake_o
);

    // ---------------- host port domain ----------------
    logic [5:0]  bit_cnt_q;                     // bits received in this frame
    logic [15:0] shift_q;                       // incoming bit shift register
    logic [15:0] hdr_q;                         // held header: address and read bit
    logic [7:0]  wdata_q;                       // held write data
    logic        hdr_tgl_q;                     // toggles when a header is complete
    logic        wr_tgl_q;                      // toggles when a write frame is complete
    logic [6:0]  miso_sh_q;                     // outgoing read data
    logic [7:0]  rdata_q;                       // read word, core domain, held stable

    // bit counter, cleared while chip select is high
    always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            bit_cnt_q <= 6'h00;
        end else if (bit_cnt_q != tir_pkg::FR_DONE) begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
        end
    end

    // input shifter, msb first
    always_ff @(posedge spi_sck_i) begin
        shift_q <= {shift_q[14:0], spi_mosi_i};
    end

    // header capture; it stays put until the next frame's header
    always_ff @(posedge spi_sck_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hdr_q     <= 16'h0000;
            hdr_tgl_q <= 1'b0;
        end else if (!spi_cs_n_i && bit_cnt_q == tir_pkg::FR_HDR_LAST) begin
            hdr_q     <= {shift_q[14:0], spi_mosi_i};
            hdr_tgl_q <= ~hdr_tgl_q;
        end
    end

    // write data capture on the last bit of a write frame
    always_ff @(posedge spi_sck_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wdata_q  <= 8'h00;
            wr_tgl_q <= 1'b0;
        end else if (!spi_cs_n_i && bit_cnt_q == tir_pkg::FR_LAST &&
                     !hdr_q[tir_pkg::HDR_RD_BIT]) begin
            wdata_q  <= {shift_q[6:0], spi_mosi_i};
            wr_tgl_q <= ~wr_tgl_q;
        end
    end

    // output shifter: rdata_q has been stable for the turnaround byte
    always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            spi_miso_o <= 1'b0;
            miso_sh_q  <= 7'h00;
        end else if (bit_cnt_q == tir_pkg::FR_DATA_FIRST) begin
            spi_miso_o <= rdata_q[7];
            miso_sh_q  <= rdata_q[6:0];
        end else begin
            spi_miso_o <= miso_sh_q[6];
            miso_sh_q  <= {miso_sh_q[5:0], 1'b0};
        end
    end

    // data out driven once the first clock falls inside a frame
    always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            spi_miso_oe_o <= 1'b0;
        end else begin
            spi_miso_oe_o <= 1'b1;
        end
    end

    // ---------------- core domain ----------------
    logic [2:0]  hdr_sync_q;                    // header toggle synchroniser and history
    logic [2:0]  wr_sync_q;                     // write toggle synchroniser and history
    logic [13:0] ev_meta_q;                     // first stage for event inputs
    logic [13:0] ev_q;                          // synchronised event inputs
    logic        wake_prev_q;                   // wake pin level one cycle back
    logic        hdr_fire;                      // header arrived
    logic        wr_fire;                       // write arrived
    logic [11:0] addr;                          // register address of current frame
    logic [7:0]  can_en_q;
    logic [7:0]  gpio_en_q;
    logic [7:0]  sys_stat_q;
    logic [7:0]  can_stat_q;
    logic [7:0]  pn_stat_q;
    logic [7:0]  gpio_stat_q;
    logic [7:0]  sys_set;                       // set terms per register
    logic [7:0]  can_set;
    logic [7:0]  pn_set;
    logic [7:0]  gpio_set;
    logic [7:0]  can_msk;                       // implemented CAN bits for the variant
    logic [7:0]  gpio_msk;                      // implemented pin bits for the variant
    logic        pending;                       // any enabled flag standing
    logic [7:0]  rdata_d;

    // toggle synchronisers; the first stage feeds no logic, the second and third stages are compared
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            hdr_sync_q <= 3'h0;
            wr_sync_q  <= 3'h0;
        end else begin
            hdr_sync_q <= {hdr_sync_q[1:0], hdr_tgl_q};
            wr_sync_q  <= {wr_sync_q[1:0], wr_tgl_q};
        end
    end

    assign hdr_fire = hdr_sync_q[2] ^ hdr_sync_q[1];
    assign wr_fire  = wr_sync_q[2] ^ wr_sync_q[1];
    assign addr     = hdr_q[15:4];
    assign can_msk  = EXTENDED ? tir_pkg::MSK_CAN_EXT : tir_pkg::MSK_CAN_BASIC;
    assign gpio_msk = EXTENDED ? tir_pkg::MSK_GPIO : 8'h00;

    // two-stage synchronisers for asynchronous event levels
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ev_meta_q   <= 14'h0000;
            ev_q        <= 14'h0000;
            wake_prev_q <= 1'b0;
        end else begin
            ev_meta_q   <= {pin_event_i, frame_error_i, tx_timeout_i, tx2_timeout_i,
                            bus_dominant_i, bus_silence_i, wake_pin_i, logic_uv_long_i,
                            core_uv_i, serial_fail_i, overtemp_i, can_wake_i};
            ev_q        <= ev_meta_q;
            wake_prev_q <= ev_q[5];
        end
    end

    // set terms from synchronised events
    always_comb begin
        sys_set                        = 8'h00;
        sys_set[tir_pkg::SYS_CANWAKE]  = ev_q[0];
        sys_set[tir_pkg::SYS_OVERTEMP] = ev_q[1];
        sys_set[tir_pkg::SYS_SERFAIL]  = ev_q[2];
        sys_set[tir_pkg::SYS_UVCORE]   = ev_q[3];
        sys_set[tir_pkg::SYS_UVLOGIC]  = ev_q[4];
        sys_set[tir_pkg::SYS_WRISE]    = ev_q[5] & ~wake_prev_q;
        sys_set[tir_pkg::SYS_WFALL]    = ~ev_q[5] & wake_prev_q;
        can_set                        = 8'h00;
        can_set[tir_pkg::CAN_SIL]      = ev_q[6];
        can_set[tir_pkg::CAN_DOM]      = ev_q[7];
        can_set[tir_pkg::CAN_TX2]      = ev_q[8] & EXTENDED;
        can_set[tir_pkg::CAN_TX]       = ev_q[9];
        pn_set                         = 8'h00;
        pn_set[tir_pkg::PN_FERR]       = ev_q[10];
        // pin events sit at the top of the event vector; basic variant has no pins
        gpio_set                       = {5'h00, ev_q[13:11]} & gpio_msk;
    end

    // enable registers, read/write, reserved bits held at zero
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            can_en_q  <= tir_pkg::RST_CAN_EN;
            gpio_en_q <= tir_pkg::RST_GPIO_EN;
        end else if (wr_fire && addr == tir_pkg::OFS_CAN_EN) begin
            can_en_q  <= wdata_q & can_msk;
        end else if (wr_fire && addr == tir_pkg::OFS_GPIO_EN) begin
            gpio_en_q <= wdata_q & gpio_msk;
        end
    end

    // status registers: sticky, written ones clear, a new event wins
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            sys_stat_q  <= tir_pkg::RST_SYS_STAT;
            can_stat_q  <= tir_pkg::RST_CAN_STAT;
            pn_stat_q   <= tir_pkg::RST_PN_STAT;
            gpio_stat_q <= tir_pkg::RST_GPIO_STAT;
        end else begin
            sys_stat_q  <= (sys_stat_q & ~w1c(tir_pkg::OFS_SYS_STAT)) | sys_set;
            can_stat_q  <= ((can_stat_q & ~w1c(tir_pkg::OFS_CAN_STAT)) | can_set) & can_msk;
            pn_stat_q   <= ((pn_stat_q & ~w1c(tir_pkg::OFS_PN_STAT)) | pn_set)
                           & tir_pkg::MSK_PN;
            gpio_stat_q <= ((gpio_stat_q & ~w1c(tir_pkg::OFS_GPIO_STAT)) | gpio_set)
                           & gpio_msk;
        end
    end

    // clear mask for one register address, zeros leave flags alone
    function automatic logic [7:0] w1c(input logic [11:0] ofs);
        w1c = (wr_fire && addr == ofs) ? wdata_q : 8'h00;
    endfunction

    // pending request: flag set and enabled; power-on and frame error always enabled
    always_comb begin
        pending = sys_stat_q[tir_pkg::SYS_PWRON] | pn_stat_q[tir_pkg::PN_FERR]
                | (|(sys_stat_q[6:0] & sys_irq_en_i))
                | (|(can_stat_q & can_en_q))
                | (|(gpio_stat_q & gpio_en_q));
    end

    // interrupt and wake requests, registered
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            irq_o  <= pending;
            wake_o <= sys_set[tir_pkg::SYS_CANWAKE] | sys_set[tir_pkg::SYS_WFALL];
        end
    end

    // read word for the addressed register; unmapped reads zero
    always_comb begin
        unique case (addr)
            tir_pkg::OFS_CAN_EN:    rdata_d = can_en_q;
            tir_pkg::OFS_GPIO_EN:   rdata_d = gpio_en_q;
            tir_pkg::OFS_SYS_STAT:  rdata_d = sys_stat_q;
            tir_pkg::OFS_CAN_STAT:  rdata_d = can_stat_q;
            tir_pkg::OFS_PN_STAT:   rdata_d = pn_stat_q;
            tir_pkg::OFS_GPIO_STAT: rdata_d = gpio_stat_q;
            default:                rdata_d = 8'h00;
        endcase
    end

    // read word is loaded once per header and then held for the host port
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= 8'h00;
        end else if (hdr_fire) begin
            rdata_q <= rdata_d;
        end
    end

    // ---------------- checks ----------------
    AST_PWRON_AFTER_RESET: assert property (@(posedge clk_i)
        $rose(reset_n_i) |-> sys_stat_q[tir_pkg::SYS_PWRON] && can_en_q == 8'h00)
        else $error("power-on flag or enables wrong after reset");

    AST_EN_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_fire && addr == tir_pkg::OFS_CAN_EN |=> can_en_q == ($past(wdata_q) & can_msk))
        else $error("CAN enable write not stored");

    AST_GPIO_EN_WRITE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_fire && addr == tir_pkg::OFS_GPIO_EN |=> gpio_en_q == ($past(wdata_q) & gpio_msk))
        else $error("pin enable write not stored");

    AST_SET_WINS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        can_set[tir_pkg::CAN_SIL] |=> can_stat_q[tir_pkg::CAN_SIL])
        else $error("bus silence event lost");

    AST_STICKY: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sys_stat_q[tir_pkg::SYS_OVERTEMP] && !(wr_fire && addr == tir_pkg::OFS_SYS_STAT)
        |=> sys_stat_q[tir_pkg::SYS_OVERTEMP])
        else $error("overtemperature flag dropped without a clear");

    AST_W1C: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_fire && addr == tir_pkg::OFS_CAN_STAT && wdata_q[tir_pkg::CAN_TX]
        && !can_set[tir_pkg::CAN_TX] |=> !can_stat_q[tir_pkg::CAN_TX])
        else $error("written one did not clear timeout flag");

    AST_WRITE_ZERO: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        wr_fire && addr == tir_pkg::OFS_PN_STAT && !wdata_q[tir_pkg::PN_FERR]
        && pn_stat_q[tir_pkg::PN_FERR] |=> pn_stat_q[tir_pkg::PN_FERR])
        else $error("written zero cleared frame error flag");

    AST_IRQ_ALWAYS_ON: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        pn_stat_q[tir_pkg::PN_FERR] |=> irq_o)
        else $error("frame error did not raise the request");

    AST_IRQ_GATED: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sys_stat_q == 8'h00 && pn_stat_q == 8'h00 && gpio_stat_q == 8'h00
        && can_stat_q == 8'h04 && !can_en_q[tir_pkg::CAN_DOM] |=> !irq_o)
        else $error("disabled bus dominant flag raised the request");

    AST_WAKE_FALL: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !ev_q[5] && wake_prev_q |=> wake_o && sys_stat_q[tir_pkg::SYS_WFALL])
        else $error("wake pin fall did not wake and flag");

endmodule // tir_regs

// file: inc/tir_pkg.sv
// constants for the transceiver interrupt enable and status register block
// assumes a serial host port (chip select, clock, data in, data out) and a core clock
package tir_pkg;
    // register addresses on the serial port
    localparam int          ADDR_W         = 12;
    localparam logic [11:0] OFS_CAN_EN     = 12'h011;
    localparam logic [11:0] OFS_GPIO_EN    = 12'h012;
    localparam logic [11:0] OFS_SYS_STAT   = 12'h060;
    localparam logic [11:0] OFS_CAN_STAT   = 12'h061;
    localparam logic [11:0] OFS_PN_STAT    = 12'h062;
    localparam logic [11:0] OFS_GPIO_STAT  = 12'h063;
    // reset values
    localparam logic [7:0]  RST_CAN_EN     = 8'h00;
    localparam logic [7:0]  RST_GPIO_EN    = 8'h00;
    localparam logic [7:0]  RST_SYS_STAT   = 8'h80;
    localparam logic [7:0]  RST_CAN_STAT   = 8'h00;
    localparam logic [7:0]  RST_PN_STAT    = 8'h00;
    localparam logic [7:0]  RST_GPIO_STAT  = 8'h00;
    // implemented bits per register and variant
    localparam logic [7:0]  MSK_CAN_EXT    = 8'h0F;
    localparam logic [7:0]  MSK_CAN_BASIC  = 8'h0D;
    localparam logic [7:0]  MSK_GPIO       = 8'h07;
    localparam logic [7:0]  MSK_PN         = 8'h04;
    // field positions, system status
    localparam int          SYS_PWRON      = 7;
    localparam int          SYS_CANWAKE    = 6;
    localparam int          SYS_OVERTEMP   = 5;
    localparam int          SYS_SERFAIL    = 4;
    localparam int          SYS_UVCORE     = 3;
    localparam int          SYS_UVLOGIC    = 2;
    localparam int          SYS_WRISE      = 1;
    localparam int          SYS_WFALL      = 0;
    // field positions, CAN status and enable
    localparam int          CAN_SIL        = 3;
    localparam int          CAN_DOM        = 2;
    localparam int          CAN_TX2        = 1;
    localparam int          CAN_TX         = 0;
    // field position, partial networking status
    localparam int          PN_FERR        = 2;
    // serial frame layout: 12 address bits, read bit, 3 pad, 8 turnaround, 8 data
    localparam logic [5:0]  FR_HDR_LAST    = 6'd15;
    localparam logic [5:0]  FR_DATA_FIRST  = 6'd24;
    localparam logic [5:0]  FR_LAST        = 6'd31;
    localparam logic [5:0]  FR_DONE        = 6'd32;
    localparam int          HDR_RD_BIT     = 3;
endpackage : tir_pkg

// file: design/tir_regs_fix.sv
`timescale 1ns/1ps
// note: none

// file: dv/tir_host.sv
// host model: serial port master in mode 0, 30 ns clock running only inside frames
// assumes the block samples on the clock rise and shifts read data out on the fall
`timescale 1ns/1ps
module tir_host (
    // serial port pins
    output logic      spi_sck_o,
    output logic      spi_cs_n_o,
    output logic      spi_mosi_o,
    input  wire logic spi_miso_i
);
    // idle: clock low and still, chip select high
    initial begin
        spi_sck_o  = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end
    // one frame: address, read bit, pad, turnaround, data, all msb first
    task automatic xfer(input logic [11:0] addr, input logic rd_en,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [31:0] fr;
        fr         = {addr, rd_en, 3'h0, 8'h00, wdata};
        rdata      = 8'h00;
        spi_cs_n_o = 1'b0;
        for (int k = 31; k >= 0; k--) begin
            spi_mosi_o = fr[k];
            #15 spi_sck_o = 1'b1;
            // data bits are taken on rises 25 to 32
            if (k < 8) rdata = {rdata[6:0], spi_miso_i};
            #15 spi_sck_o = 1'b0;
        end
        #15 spi_cs_n_o = 1'b1;
        // released data line shows the inverse of its last value
        spi_mosi_o = ~spi_mosi_o;
        // gap lets a write land in the core before the next header
        #150;
    endtask
endmodule // tir_host

// file: dv/tb_tir_regs.sv
// bench for the interrupt register block: host frames, event pulses, request outputs
// assumes the host model tir_host and both variants of the block on one host port
`timescale 1ns/1ps
module tb_tir_regs;
    logic        clk_i;          // core clock
    logic        reset_n_i;      // synchronous reset, active low
    logic        spi_sck;        // host port wires
    logic        spi_cs_n;
    logic        spi_mosi;
    logic        spi_miso;
    logic        spi_miso_oe;
    logic        spi_miso_b;     // data out of the basic variant
    logic        host_miso;      // data out seen by the host
    logic        sel_basic;      // host reads the basic variant
    logic        irq_b;          // request of the basic variant
    logic [13:0] ev;             // event levels, one per source
    logic [6:0]  sys_en;         // system enables
    logic        irq_o;
    logic        wake_o;
    logic [7:0]  rd;             // last read word
    int          error_cnt;
    int          checks_done;
    int          wake_seen;      // cycles with a wake request
    tir_regs tir_regs_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .spi_sck_i(spi_sck),
        .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi), .spi_miso_o(spi_miso),
        .spi_miso_oe_o(spi_miso_oe), .can_wake_i(ev[0]), .overtemp_i(ev[1]),
        .serial_fail_i(ev[2]), .core_uv_i(ev[3]), .logic_uv_long_i(ev[4]),
        .wake_pin_i(ev[5]), .bus_silence_i(ev[6]), .bus_dominant_i(ev[7]),
        .tx2_timeout_i(ev[8]), .tx_timeout_i(ev[9]), .frame_error_i(ev[10]),
        .pin_event_i(ev[13:11]), .sys_irq_en_i(sys_en), .irq_o(irq_o), .wake_o(wake_o));
    // basic variant on the same host wires: no second timeout, no pins
    tir_regs #(.EXTENDED(1'b0)) tir_regs_basic_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .spi_sck_i(spi_sck), .spi_cs_n_i(spi_cs_n), .spi_mosi_i(spi_mosi),
        .spi_miso_o(spi_miso_b), .spi_miso_oe_o(), .can_wake_i(ev[0]), .overtemp_i(ev[1]),
        .serial_fail_i(ev[2]), .core_uv_i(ev[3]), .logic_uv_long_i(ev[4]),
        .wake_pin_i(ev[5]), .bus_silence_i(ev[6]), .bus_dominant_i(ev[7]),
        .tx2_timeout_i(ev[8]), .tx_timeout_i(ev[9]), .frame_error_i(ev[10]),
        .pin_event_i(ev[13:11]), .sys_irq_en_i(sys_en), .irq_o(irq_b), .wake_o());
    // host reads back from whichever variant is selected
    assign host_miso = sel_basic ? spi_miso_b : spi_miso;
    tir_host tir_host_i (.spi_sck_o(spi_sck), .spi_cs_n_o(spi_cs_n), .spi_mosi_o(spi_mosi),
        .spi_miso_i(host_miso));
    // core clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // counts wake request cycles
    always @(posedge clk_i) begin
        if (wake_o === 1'b1) wake_seen++;
    end
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic clks(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        tir_host_i.xfer(a, 1'b1, 8'h00, rd);
        chk(rd, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        tir_host_i.xfer(a, 1'b0, d, rd);
    endtask
    // reset values, power-on flag and its clear
    task automatic t_reset;
        chk({7'h00, spi_miso_oe}, 8'h00);
        chk({7'h00, irq_o}, 8'h01);
        rdc(12'h011, 8'h00);
        rdc(12'h012, 8'h00);
        rdc(12'h060, 8'h80);
        rdc(12'h061, 8'h00);
        rdc(12'h062, 8'h00);
        rdc(12'h063, 8'h00);
        wr(12'h060, 8'h7F);
        rdc(12'h060, 8'h80);
        wr(12'h060, 8'h80);
        rdc(12'h060, 8'h00);
        clks(2);
        chk({7'h00, irq_o}, 8'h00);
    endtask
    // enable registers with implemented bits only, and an unmapped place
    task automatic t_enables;
        wr(12'h011, 8'h0F);
        rdc(12'h011, 8'h0F);
        wr(12'h011, 8'h05);
        rdc(12'h011, 8'h05);
        wr(12'h012, 8'h07);
        rdc(12'h012, 8'h07);
        wr(12'h012, 8'h02);
        rdc(12'h012, 8'h02);
        wr(12'h012, 8'h00);
        wr(12'h011, 8'h00);
        wr(12'h123, 8'hFF);
        rdc(12'h123, 8'h00);
        rdc(12'h011, 8'h00);
    endtask
    // every source once: latch, stay, zero write, one write
    task automatic t_events;
        logic [11:0] a;
        logic [7:0]  m;
        for (int i = 0; i < 14; i++) begin
            a = (i < 6) ? 12'h060 : (i < 10) ? 12'h061 : (i == 10) ? 12'h062 : 12'h063;
            m = (i < 5) ? 8'h40 >> i : (i == 5) ? 8'h03 : (i < 10) ? 8'h08 >> (i - 6)
              : (i == 10) ? 8'h04 : 8'h01 << (i - 11);
            wake_seen = 0;
            // pin sources only set their status flags; pin events never raise the wake request
            @(posedge clk_i) ev[i] <= 1'b1;
            clks(10);
            ev[i] <= 1'b0;
            clks(10);
            chk({7'h00, irq_o}, {7'h00, i == 10});
            chk({7'h00, wake_seen > 0}, {7'h00, i == 0 || i == 5});
            wr(a, 8'h00);
            rdc(a, m);
            wr(a, (i < 6) ? m : 8'hFF);
            rdc(a, 8'h00);
            clks(2);
            chk({7'h00, irq_o}, 8'h00);
        end
    endtask
    // enabled requests, masking, set winning over clear
    task automatic t_irq;
        wr(12'h011, 8'h08);
        @(posedge clk_i) ev[6] <= 1'b1;
        clks(6);
        chk({7'h00, irq_o}, 8'h01);
        wr(12'h061, 8'hFF);
        rdc(12'h061, 8'h08);
        @(posedge clk_i) ev[6] <= 1'b0;
        clks(6);
        wr(12'h011, 8'h00);
        clks(3);
        chk({7'h00, irq_o}, 8'h00);
        wr(12'h061, 8'hFF);
        @(posedge clk_i) sys_en <= 7'h20;
        ev[1] <= 1'b1;
        clks(6);
        ev[1] <= 1'b0;
        clks(3);
        chk({7'h00, irq_o}, 8'h01);
        wr(12'h060, 8'h20);
        clks(3);
        chk({7'h00, irq_o}, 8'h00);
        rdc(12'h061, 8'h00);
    endtask
    // basic variant: second timeout and pin registers absent
    task automatic t_basic;
        sel_basic = 1'b1;
        wr(12'h011, 8'h0F);
        rdc(12'h011, 8'h0D);
        wr(12'h012, 8'h07);
        rdc(12'h012, 8'h00);
        @(posedge clk_i) ev[8] <= 1'b1;
        ev[11] <= 1'b1;
        clks(10);
        ev[8]  <= 1'b0;
        ev[11] <= 1'b0;
        clks(10);
        rdc(12'h061, 8'h00);
        rdc(12'h063, 8'h00);
        chk({7'h00, irq_b}, 8'h00);
        chk({7'h00, irq_o}, 8'h01);
    endtask
    // watchdog well beyond the expected run of about 113 us
    initial begin
        #500us;
        error_cnt++;
        report_and_stop();
    end
    // main sequence
    initial begin
        reset_n_i   = 1'b0;
        ev          = 14'h0000;
        sys_en      = 7'h00;
        error_cnt   = 0;
        checks_done = 0;
        wake_seen   = 0;
        sel_basic   = 1'b0;
        clks(8);
        reset_n_i <= 1'b1;
        clks(2);
        t_reset();
        t_enables();
        t_events();
        t_irq();
        t_basic();
        report_and_stop();
    end
endmodule // tb_tir_regs
